// file: verilog/ats_pkg.sv
package ats_pkg;

    // ****************************************
    // Timing.
    // ****************************************
    localparam longint unsigned ATS_CLK_HZ = 200000000;
    localparam longint unsigned ATS_TIMEOUT_S = 12;
    localparam logic [31:0] ATS_TIMEOUT_CYC = 32'(ATS_TIMEOUT_S * ATS_CLK_HZ);
    localparam longint unsigned ATS_STEP_US = 1000;
    localparam logic [31:0] ATS_STEP_CYC = 32'(ATS_STEP_US * ATS_CLK_HZ / 1000000);

    // ****************************************
    // Register map and fields.
    // ****************************************
    localparam logic [7:0] ATS_OFS_CTRL = 8'h00;
    localparam logic [7:0] ATS_OFS_STAT = 8'h04;
    localparam logic [7:0] ATS_OFS_IRQ_ST = 8'h08;
    localparam logic [7:0] ATS_OFS_IRQ_MSK = 8'h0c;
    localparam logic [7:0] ATS_OFS_RELAY = 8'h10;
    localparam int ATS_CTRL_RETUNE = 0;
    localparam int ATS_CTRL_RECHECK = 1;
    localparam int ATS_IRQ_N = 4;
    localparam int ATS_IRQ_MATCH = 0;
    localparam int ATS_IRQ_TMO = 1;
    localparam int ATS_IRQ_BAND = 2;
    localparam int ATS_IRQ_CHKFAIL = 3;
    localparam logic [3:0] ATS_MSK_RST = 4'h0;

    // ****************************************
    // Bands, selector and relay banks.
    // ****************************************
    localparam logic [10:0] ATS_L_ALL = 11'h7ff;
    localparam logic [2:0] ATS_BAND_2M = 3'h1;
    localparam logic [2:0] ATS_BAND_3M = 3'h2;
    localparam logic [2:0] ATS_BAND_5M = 3'h3;
    localparam logic [2:0] ATS_BAND_8M = 3'h4;
    localparam logic [2:0] ATS_BAND_12M = 3'h5;
    localparam logic [2:0] ATS_BAND_20M = 3'h6;
    localparam logic [1:0] ATS_SEL_DIRECT = 2'h0;
    localparam logic [1:0] ATS_SEL_BNC = 2'h1;
    localparam logic [1:0] ATS_SEL_WHIP = 2'h2;

    typedef enum logic [4:0] {
        ATS_IDLE = 5'h01,
        ATS_LSTEP = 5'h02,
        ATS_CSTEP = 5'h04,
        ATS_HOLD = 5'h08,
        ATS_CHECK = 5'h10
    } ats_state_t;

    typedef struct packed {
        logic [10:0] ind;
        logic [7:0] cap;
    } ats_relay_t;

    typedef struct packed {
        logic key;
        logic retune;
        logic recheck;
        logic z_ok;
        logic vswr_ok;
        logic [2:0] band;
        logic [1:0] sel;
    } ats_pins_t;

    typedef struct packed {
        logic [1:0] lsh;
        logic [1:0] csh;
        logic [7:0] ctop;
    } ats_band_t;

endpackage : ats_pkg

// file: verilog/ats_sequencer.sv
`timescale 1ns/1ps

// Summary of operation
// - Tuning starts on key activation only while retune or recheck is pending.
// - While tuning-active, relay supply and transfer relay are on.
// - Inductor phase advances a binary count once per element step.
// - Each inductor count bit drives one relay of doubled weight.
// - Impedance comparator trip stops inductor count and starts capacitor phase.
// - Capacitor phase advances a binary count while watching the VSWR comparator.
// - VSWR comparator trip stops the capacitor count as a successful match.
// - Capacitor end without match clears capacitors and adds one inductor.
// - On match, tuning-active, transfer and supply drop; relays stay put.
// - Band selects which inductor becomes the least significant count bit.
// - Band selects the capacitor subset used by the count.
// - No match within the timeout releases no-tune and raises tune fault.
// - All band inputs at ground raise the tune fault.
// - No tuning starts in receive; a retune request there clears all elements.
// - Direct selector position bypasses the tuner; others route through it.
// - Recheck measures VSWR; pass resumes, fail clears elements and leaves a retune pending.
module ats_sequencer
    import ats_pkg::*;
#(
    parameter logic [31:0] TIMEOUT_CYC = ATS_TIMEOUT_CYC,
    parameter logic [31:0] STEP_CYC = ATS_STEP_CYC
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic reset,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Radio and sensor pins.
    input wire logic key_active,
    input wire logic retune_req,
    input wire logic recheck_req,
    input wire logic z_ok,
    input wire logic vswr_ok,
    input wire logic [2:0] band_sel,
    input wire logic [1:0] antenna_selector,
    // Outputs.
    output ats_relay_t relays,
    output logic tuning_active,
    output logic relay_supply_en,
    output logic transfer_relay,
    output logic no_tune_ok,
    output logic tune_fault,
    output logic tuner_bypass,
    output logic route_bnc,
    output logic route_whip,
    output logic irq
);

    // ****************************************
    // Input synchronisers.
    // ****************************************
    ats_pins_t pin_raw;
    ats_pins_t s1_ff, s2_ff, s3_ff, pin_ff;
    assign pin_raw = '{key_active, retune_req, recheck_req, z_ok, vswr_ok,
                       band_sel, antenna_selector};

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            pin_ff <= '0;
        end else begin
            s1_ff <= pin_raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (int i = 0; i < $bits(ats_pins_t); i++) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    pin_ff[i] <= s3_ff[i];
                end
            end
        end
    end

    logic [2:0] prime_cnt_ff;
    logic primed;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            prime_cnt_ff <= '0;
        end else if (!primed) begin
            prime_cnt_ff <= prime_cnt_ff + 3'h1;
        end
    end
    assign primed = prime_cnt_ff == 3'h4;

    logic key_d_ff, ret_d_ff, chk_d_ff;
    logic key_rise, ret_rise, chk_rise;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            key_d_ff <= 1'b0;
            ret_d_ff <= 1'b0;
            chk_d_ff <= 1'b0;
        end else begin
            key_d_ff <= pin_ff.key;
            ret_d_ff <= pin_ff.retune;
            chk_d_ff <= pin_ff.recheck;
        end
    end
    assign key_rise = pin_ff.key && !key_d_ff;

    // ****************************************
    // Registers written by software.
    // ****************************************
    logic sw_ret, sw_chk, wr_ctrl;
    logic [3:0] msk_ff, ist_ff, ev;
    assign wr_ctrl = reg_wr && reg_addr == ATS_OFS_CTRL;
    assign sw_ret = wr_ctrl && reg_wdata[ATS_CTRL_RETUNE];
    assign sw_chk = wr_ctrl && reg_wdata[ATS_CTRL_RECHECK];
    assign ret_rise = (pin_ff.retune && !ret_d_ff) || sw_ret;
    assign chk_rise = (pin_ff.recheck && !chk_d_ff) || sw_chk;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            msk_ff <= ATS_MSK_RST;
        end else if (reg_wr && reg_addr == ATS_OFS_IRQ_MSK) begin
            msk_ff <= reg_wdata[ATS_IRQ_N-1:0];
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ist_ff <= '0;
        end else if (reg_wr && reg_addr == ATS_OFS_IRQ_ST) begin
            ist_ff <= (ist_ff & ~reg_wdata[ATS_IRQ_N-1:0]) | ev;
        end else begin
            ist_ff <= ist_ff | ev;
        end
    end
    assign irq = |(ist_ff & msk_ff);

    // ****************************************
    // Band decode.
    // ****************************************
    ats_band_t cfg, cfg_ff;
    logic band_bad;
    always_comb begin
        band_bad = 1'b0;
        unique case (pin_ff.band)
            ATS_BAND_2M: cfg = '{2'h3, 2'h3, 8'h1f};
            ATS_BAND_3M: cfg = '{2'h2, 2'h3, 8'h1f};
            ATS_BAND_5M: cfg = '{2'h2, 2'h2, 8'h1f};
            ATS_BAND_8M: cfg = '{2'h1, 2'h1, 8'h1f};
            ATS_BAND_12M: cfg = '{2'h0, 2'h1, 8'h0f};
            ATS_BAND_20M: cfg = '{2'h0, 2'h0, 8'h0f};
            default: begin
                cfg = '{2'h0, 2'h0, 8'h0f};
                band_bad = primed;
            end
        endcase
    end

    // ****************************************
    // Step tick and timeout.
    // ****************************************
    logic [31:0] step_cnt_ff, tmo_cnt_ff;
    logic step, tmo_hit, start;
    ats_state_t st_ff;
    logic tuning;
    assign tuning = st_ff inside {ATS_LSTEP, ATS_CSTEP, ATS_HOLD};

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            step_cnt_ff <= '0;
        end else if (step || start) begin
            step_cnt_ff <= '0;
        end else begin
            step_cnt_ff <= step_cnt_ff + 32'h1;
        end
    end
    assign step = step_cnt_ff == STEP_CYC - 32'h1;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            tmo_cnt_ff <= '0;
        end else if (!tuning) begin
            tmo_cnt_ff <= '0;
        end else begin
            tmo_cnt_ff <= tmo_cnt_ff + 32'h1;
        end
    end
    assign tmo_hit = tuning && tmo_cnt_ff == TIMEOUT_CYC - 32'h1;

    // ****************************************
    // Request tracking.
    // ****************************************
    logic ret_pend_ff, chk_pend_ff, chk_fail;
    assign start = st_ff == ATS_IDLE && key_rise && !band_bad
                   && (ret_pend_ff || chk_pend_ff);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ret_pend_ff <= 1'b0;
            chk_pend_ff <= 1'b0;
        end else begin
            if (ret_rise || chk_fail) begin
                ret_pend_ff <= 1'b1;
            end else if (start) begin
                ret_pend_ff <= 1'b0;
            end
            if (chk_rise) begin
                chk_pend_ff <= 1'b1;
            end else if (start) begin
                chk_pend_ff <= 1'b0;
            end
        end
    end

    // ****************************************
    // Tuning sequence.
    // ****************************************
    logic [10:0] l_cnt_ff;
    logic [7:0] c_cnt_ff;
    logic l_top, c_top, match;
    assign l_top = l_cnt_ff == (ATS_L_ALL >> cfg_ff.lsh);
    assign c_top = c_cnt_ff == cfg_ff.ctop;
    assign match = st_ff == ATS_CSTEP && step && pin_ff.vswr_ok;
    assign chk_fail = st_ff == ATS_CHECK && step && !pin_ff.vswr_ok;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_ff <= ATS_IDLE;
            l_cnt_ff <= '0;
            c_cnt_ff <= '0;
            cfg_ff <= '0;
        end else begin
            unique case (st_ff)
                ATS_IDLE: begin
                    if (ret_rise) begin
                        l_cnt_ff <= '0;
                        c_cnt_ff <= '0;
                    end
                    if (start && ret_pend_ff) begin
                        st_ff <= ATS_LSTEP;
                        cfg_ff <= cfg;
                        l_cnt_ff <= '0;
                        c_cnt_ff <= '0;
                    end else if (start) begin
                        st_ff <= ATS_CHECK;
                    end
                end
                ATS_LSTEP: begin
                    if (tmo_hit) begin
                        st_ff <= ATS_IDLE;
                    end else if (step && pin_ff.z_ok) begin
                        st_ff <= ATS_CSTEP;
                        c_cnt_ff <= '0;
                    end else if (step && l_top) begin
                        st_ff <= ATS_HOLD;
                    end else if (step) begin
                        l_cnt_ff <= l_cnt_ff + 11'h1;
                    end
                end
                ATS_CSTEP: begin
                    if (tmo_hit) begin
                        st_ff <= ATS_IDLE;
                    end else if (match) begin
                        st_ff <= ATS_IDLE;
                    end else if (step && c_top) begin
                        c_cnt_ff <= '0;
                        if (l_top) begin
                            st_ff <= ATS_HOLD;
                        end else begin
                            l_cnt_ff <= l_cnt_ff + 11'h1;
                        end
                    end else if (step) begin
                        c_cnt_ff <= c_cnt_ff + 8'h1;
                    end
                end
                ATS_HOLD: begin
                    if (tmo_hit) begin
                        st_ff <= ATS_IDLE;
                    end
                end
                ATS_CHECK: begin
                    if (step) begin
                        st_ff <= ATS_IDLE;
                    end
                    if (chk_fail) begin
                        l_cnt_ff <= '0;
                        c_cnt_ff <= '0;
                    end
                end
                default: st_ff <= ATS_IDLE;
            endcase
        end
    end

    // ****************************************
    // Output registers.
    // ****************************************
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            relays <= '0;
            tuning_active <= 1'b0;
            relay_supply_en <= 1'b0;
            transfer_relay <= 1'b0;
            no_tune_ok <= 1'b1;
            tune_fault <= 1'b0;
            tuner_bypass <= 1'b1;
            route_bnc <= 1'b0;
            route_whip <= 1'b0;
        end else begin
            relays.ind <= 11'(l_cnt_ff << cfg_ff.lsh);
            relays.cap <= 8'(c_cnt_ff << cfg_ff.csh);
            tuning_active <= tuning || st_ff == ATS_CHECK;
            relay_supply_en <= tuning || st_ff == ATS_CHECK;
            transfer_relay <= tuning || st_ff == ATS_CHECK;
            if (tmo_hit) begin
                no_tune_ok <= 1'b0;
            end else if (start) begin
                no_tune_ok <= 1'b1;
            end
            tune_fault <= band_bad || !no_tune_ok;
            tuner_bypass <= pin_ff.sel == ATS_SEL_DIRECT;
            route_bnc <= pin_ff.sel == ATS_SEL_BNC;
            route_whip <= pin_ff.sel == ATS_SEL_WHIP;
        end
    end

    always_comb begin
        ev = '0;
        ev[ATS_IRQ_MATCH] = match;
        ev[ATS_IRQ_TMO] = tmo_hit;
        ev[ATS_IRQ_BAND] = band_bad && !tune_fault;
        ev[ATS_IRQ_CHKFAIL] = chk_fail;
    end

    // ****************************************
    // Register read.
    // ****************************************
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ATS_OFS_CTRL: reg_rdata <= {30'h0, chk_pend_ff, ret_pend_ff};
                ATS_OFS_STAT: reg_rdata <= {24'h0, tune_fault, no_tune_ok,
                                            tuning_active, st_ff};
                ATS_OFS_IRQ_ST: reg_rdata <= {28'h0, ist_ff};
                ATS_OFS_IRQ_MSK: reg_rdata <= {28'h0, msk_ff};
                ATS_OFS_RELAY: reg_rdata <= {13'h0, relays};
                default: reg_rdata <= '0;
            endcase
        end
    end

    // ****************************************
    // Assertions.
    // ****************************************
    sequence s_l_go;
        st_ff == ATS_LSTEP && step && !tmo_hit;
    endsequence

    sequence s_c_wrap;
        st_ff == ATS_CSTEP && step && !tmo_hit && !pin_ff.vswr_ok && c_top && !l_top;
    endsequence

    property p_start;
        @(posedge clock) disable iff (reset)
        $rose(tuning_active) |-> $past(key_rise, 2) && $past(ret_pend_ff || chk_pend_ff, 2);
    endproperty
    a_start: assert property (p_start) else $error("tuning began without request");

    property p_supply;
        @(posedge clock) disable iff (reset)
        tuning_active |-> relay_supply_en && transfer_relay && $past(st_ff) != ATS_IDLE;
    endproperty
    a_supply: assert property (p_supply) else $error("supply off while tuning");

    property p_lstep;
        @(posedge clock) disable iff (reset)
        s_l_go ##0 (!pin_ff.z_ok && !l_top) |=> l_cnt_ff == $past(l_cnt_ff) + 11'h1;
    endproperty
    a_lstep: assert property (p_lstep) else $error("inductor count did not step");

    property p_zstop;
        @(posedge clock) disable iff (reset)
        s_l_go ##0 pin_ff.z_ok |=> st_ff == ATS_CSTEP && c_cnt_ff == 8'h0 && $stable(l_cnt_ff);
    endproperty
    a_zstop: assert property (p_zstop) else $error("impedance trip ignored");

    property p_cwrap;
        @(posedge clock) disable iff (reset)
        s_c_wrap |=> c_cnt_ff == 8'h0 && l_cnt_ff == $past(l_cnt_ff) + 11'h1;
    endproperty
    a_cwrap: assert property (p_cwrap) else $error("capacitor wrap wrong");

    property p_match;
        @(posedge clock) disable iff (reset)
        match && !tmo_hit |=> ##1 !tuning_active && !transfer_relay ##1 $stable(relays);
    endproperty
    a_match: assert property (p_match) else $error("match did not end tuning");

    property p_tmo;
        @(posedge clock) disable iff (reset)
        tmo_hit |=> !no_tune_ok ##1 tune_fault;
    endproperty
    a_tmo: assert property (p_tmo) else $error("timeout fault missing");

    property p_band;
        @(posedge clock) disable iff (reset)
        primed && pin_ff.band == 3'h0 |=> tune_fault;
    endproperty
    a_band: assert property (p_band) else $error("illegal band not flagged");

    property p_rx_clear;
        @(posedge clock) disable iff (reset)
        st_ff == ATS_IDLE && ret_rise && !pin_ff.key |=> ##1 relays == '0;
    endproperty
    a_rx_clear: assert property (p_rx_clear) else $error("receive retune kept elements");

    property p_lowband;
        @(posedge clock) disable iff (reset)
        cfg_ff.lsh == 2'h3 && cfg_ff.csh == 2'h3 |=> relays.ind[2:0] == 3'h0 && relays.cap[2:0] == 3'h0;
    endproperty
    a_lowband: assert property (p_lowband) else $error("low band used bypassed relays");

    property p_chk;
        @(posedge clock) disable iff (reset)
        chk_fail |=> ret_pend_ff && st_ff == ATS_IDLE && l_cnt_ff == 11'h0;
    endproperty
    a_chk: assert property (p_chk) else $error("recheck failure not handled");

endmodule : ats_sequencer

// file: testbench/ats_bridge_model.sv
`timescale 1ns/1ps

// ****************************************
// Sensor bridge comparators seen by the tuner.
// ****************************************
module ats_bridge_model
    import ats_pkg::*;
(
    // Relay bank state and RF transfer.
    input wire ats_relay_t relays,
    input wire logic transfer_relay,
    // Targets set by the bench.
    input wire logic [10:0] z_min,
    input wire ats_relay_t match_at,
    // Comparator outputs.
    output logic z_ok,
    output logic vswr_ok
);
    // The bridge sees RF only while the transfer relay routes it there.
    assign z_ok = transfer_relay && (relays.ind >= z_min);
    assign vswr_ok = transfer_relay && (relays == match_at);
endmodule : ats_bridge_model

// file: testbench/ats_sequencer_tb_top.sv
`timescale 1ns/1ps

module ats_sequencer_tb_top
    import ats_pkg::*;
;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic key_active = 1'b0;
    logic retune_req = 1'b0;
    logic recheck_req = 1'b0;
    logic z_ok;
    logic vswr_ok;
    logic [2:0] band_sel = 3'h5;
    logic [1:0] antenna_selector = 2'h0;
    ats_relay_t relays;
    logic tuning_active;
    logic relay_supply_en;
    logic transfer_relay;
    logic no_tune_ok;
    logic tune_fault;
    logic tuner_bypass;
    logic route_bnc;
    logic route_whip;
    logic irq;
    logic [10:0] z_min = 11'h001;
    ats_relay_t match_at = '0;
    int n_fail = 0;
    int check_count = 0;
    logic [31:0] rv;
    bit hit;

    always #2.5 clock = ~clock;

    ats_sequencer #(.TIMEOUT_CYC(32'h1770), .STEP_CYC(32'h10)) i_ats_sequencer (
        .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .key_active(key_active), .retune_req(retune_req), .recheck_req(recheck_req),
        .z_ok(z_ok), .vswr_ok(vswr_ok), .band_sel(band_sel),
        .antenna_selector(antenna_selector), .relays(relays),
        .tuning_active(tuning_active), .relay_supply_en(relay_supply_en),
        .transfer_relay(transfer_relay), .no_tune_ok(no_tune_ok),
        .tune_fault(tune_fault), .tuner_bypass(tuner_bypass), .route_bnc(route_bnc),
        .route_whip(route_whip), .irq(irq)
    );

    ats_bridge_model i_ats_bridge_model (
        .relays(relays), .transfer_relay(transfer_relay), .z_min(z_min),
        .match_at(match_at), .z_ok(z_ok), .vswr_ok(vswr_ok)
    );

    // ****************************************
    // Shared tasks.
    // ****************************************
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        rv = reg_rdata;
    endtask : rd

    task automatic wait_for(input int sel, input logic val, input int bound, input bit must);
        hit = 1'b0;
        for (int i = 0; i < bound && !hit; i++) begin
            @(negedge clock);
            hit = (((sel == 0) ? tuning_active : no_tune_ok) === val);
        end
        if (must && !hit) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, !val, val);
            tally_and_finish();
        end
    endtask : wait_for

    task automatic pulse(input bit chk_req);
        @(posedge clock);
        if (chk_req) begin
            recheck_req <= 1'b1;
        end else begin
            retune_req <= 1'b1;
        end
        repeat (8) @(posedge clock);
        recheck_req <= 1'b0;
        retune_req <= 1'b0;
        repeat (8) @(posedge clock);
    endtask : pulse

    task automatic start(input bit chk_req);
        pulse(chk_req);
        key_active <= 1'b1;
        wait_for(0, 1'b1, 60, 1'b1);
        chk(32'(relay_supply_en), 32'h1);
        chk(32'(transfer_relay), 32'h1);
        wait_for(0, 1'b0, 9000, 1'b1);
        chk(32'({relay_supply_en, transfer_relay}), 32'h0);
        @(posedge clock);
        key_active <= 1'b0;
        repeat (8) @(posedge clock);
        @(negedge clock);
    endtask : start

    // ****************************************
    // Scenarios.
    // ****************************************
    task automatic s_reset_and_route();
        @(negedge clock);
        chk(32'({relays, tuning_active, no_tune_ok, tune_fault, irq}), 32'h4);
        rd(ATS_OFS_STAT);
        chk(rv, 32'h41);
        rd(8'h14);
        chk(rv, 32'h0);
        rd(ATS_OFS_IRQ_MSK);
        chk(rv, 32'h0);
        for (int s = 0; s < 3; s++) begin
            @(posedge clock);
            antenna_selector <= 2'(s);
            repeat (8) @(negedge clock);
            chk(32'({tuner_bypass, route_bnc, route_whip}), 32'(3'h4 >> s));
        end
    endtask : s_reset_and_route

    task automatic s_no_request_and_band();
        @(posedge clock);
        key_active <= 1'b1;
        wait_for(0, 1'b1, 40, 1'b0);
        chk(32'(hit), 32'h0);
        @(posedge clock);
        key_active <= 1'b0;
        band_sel <= 3'h0;
        repeat (8) @(negedge clock);
        chk(32'(tune_fault), 32'h1);
        rd(ATS_OFS_IRQ_ST);
        chk(32'(rv[ATS_IRQ_BAND]), 32'h1);
        @(posedge clock);
        band_sel <= 3'h5;
        wr(ATS_OFS_IRQ_ST, 32'hf);
        rd(ATS_OFS_IRQ_ST);
        chk(rv, 32'h0);
        repeat (8) @(negedge clock);
        chk(32'(tune_fault), 32'h0);
    endtask : s_no_request_and_band

    task automatic s_tune_band5();
        z_min <= 11'h005;
        match_at <= '{ind: 11'h005, cap: 8'h06};
        start(1'b0);
        chk(32'(relays), 32'h0506);
        chk(32'(irq), 32'h0);
        wr(ATS_OFS_IRQ_MSK, 32'h1);
        @(negedge clock);
        chk(32'(irq), 32'h1);
        wr(ATS_OFS_IRQ_ST, 32'h1);
        @(negedge clock);
        chk(32'(irq), 32'h0);
        pulse(1'b0);
        @(negedge clock);
        chk(32'({relays, tuning_active}), 32'h0);
    endtask : s_tune_band5

    task automatic s_tune_band1_and_recheck();
        @(posedge clock);
        band_sel <= 3'h1;
        z_min <= 11'h018;
        match_at <= '{ind: 11'h020, cap: 8'h10};
        start(1'b0);
        chk(32'(relays), 32'h2010);
        start(1'b1);
        chk(32'(relays), 32'h2010);
        rd(ATS_OFS_IRQ_ST);
        chk(32'(rv[ATS_IRQ_CHKFAIL]), 32'h0);
        match_at <= '0;
        start(1'b1);
        chk(32'(relays), 32'h0);
        rd(ATS_OFS_IRQ_ST);
        chk(32'(rv[ATS_IRQ_CHKFAIL]), 32'h1);
        rd(ATS_OFS_CTRL);
        chk(32'(rv[ATS_CTRL_RETUNE]), 32'h1);
    endtask : s_tune_band1_and_recheck

    task automatic s_timeout();
        @(posedge clock);
        band_sel <= 3'h6;
        z_min <= 11'h001;
        match_at <= '{ind: 11'h7ff, cap: 8'hff};
        start(1'b0);
        chk(32'({no_tune_ok, tune_fault}), 32'h1);
        rd(ATS_OFS_IRQ_ST);
        chk(32'(rv[ATS_IRQ_TMO]), 32'h1);
    endtask : s_timeout

    initial begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        repeat (8) @(posedge clock);
        s_reset_and_route();
        s_no_request_and_band();
        s_tune_band5();
        s_tune_band1_and_recheck();
        s_timeout();
        tally_and_finish();
    end
endmodule : ats_sequencer_tb_top
